// ### hw/ams_sequencer.sv
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "ams_map.svh"

// ==========================================================================
module ams_sequencer (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slow_base_clock,
   input wire logic [21:0] filter_result,
   output logic [2:0] input_select,
   output logic conv_start,
   output logic filter_start,
   output logic result_width_22,
   output logic chop_polarity,
   output logic ce_pass_start,
   output logic [2:0] meter_equation_select,
   output logic ram_we,
   output logic [2:0] ram_addr,
   output logic [31:0] ram_wdata,
   output logic cycle_end_event,
   output logic alt_cycle_active
);

   // =======================================================================
   // Register file
   logic [7:0] equation_config_q;
   logic [7:0] cycle_and_chop_config_q;
   logic [7:0] alt_and_filter_config_q;
   logic alt_pending_q;
   logic [7:0] cycle_count_q;
   logic wr_en;
   logic rd_hit;
   logic alt_rise;
   logic alt_start;
   ams_pkg::ams_fsm_e fsm_q;

   assign wr_en = psel & penable & pwrite;
   assign pready = 1'b1;

   always_comb begin
      rd_hit = 1'b1;
      prdata = 32'h0000_0000;
      case (paddr)
         `AMS_ADDR_EQU: prdata[7:0] = equation_config_q;
         `AMS_ADDR_CYC: prdata[7:0] = cycle_and_chop_config_q;
         `AMS_ADDR_ALT: prdata[7:0] = alt_and_filter_config_q;
         `AMS_ADDR_STAT: begin
            prdata[2:0] = input_select;
            prdata[3] = alt_cycle_active;
            prdata[4] = alt_pending_q;
            prdata[5] = chop_polarity;
            prdata[6] = (fsm_q == ams_pkg::AMS_SQ_RUN);
            prdata[15:8] = cycle_count_q;
         end
         default: rd_hit = 1'b0;
      endcase
   end

   // Status is read only, so a write to it is refused like a miss.
   assign pslverr = psel & penable &
      (~rd_hit | (pwrite & (paddr == `AMS_ADDR_STAT)));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         equation_config_q <= `AMS_RST_EQU;
         cycle_and_chop_config_q <= `AMS_RST_CYC;
         alt_and_filter_config_q <= `AMS_RST_ALT;
      end else if (wr_en) begin
         if (paddr == `AMS_ADDR_EQU) begin
            equation_config_q <= pwdata[7:0];
         end
         if (paddr == `AMS_ADDR_CYC) begin
            cycle_and_chop_config_q <= pwdata[7:0];
         end
         if (paddr == `AMS_ADDR_ALT) begin
            alt_and_filter_config_q <= pwdata[7:0];
         end
      end
   end

   // The rise is taken from the write data against the stored bit,
   // so even a request held for one write is seen.
   assign alt_rise = wr_en & (paddr == `AMS_ADDR_ALT) &
      pwdata[`AMS_ALT_BIT] &
      ~alt_and_filter_config_q[`AMS_ALT_BIT];

   // A new request in the same cycle as the clear wins.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         alt_pending_q <= 1'b0;
      end else if (alt_rise) begin
         alt_pending_q <= 1'b1;
      end else if (alt_start) begin
         alt_pending_q <= 1'b0;
      end
   end

   assign meter_equation_select =
      equation_config_q[`AMS_EQU_MSB:`AMS_EQU_LSB];
   assign result_width_22 =
      alt_and_filter_config_q[`AMS_FLEN_BIT];

   // =======================================================================
   // Slow clock tick
   logic tick;

   ams_edge_sync u_tick (
      .clk_sys(clk_sys),
      .reset(reset),
      .async_in(slow_base_clock),
      .rise_pulse(tick)
   );

   // =======================================================================
   // Sequence helpers
   function automatic logic [2:0] states_for(input logic [1:0] code);
      logic [2:0] n;
      n = `AMS_STATES_6;
      case (code)
         2'b00: n = `AMS_STATES_2;
         2'b01: n = `AMS_STATES_3;
         2'b10: n = `AMS_STATES_4;
         default: n = `AMS_STATES_6;
      endcase
      return n;
   endfunction : states_for

   // State number equals the regular input code; only non-voltage slots
   // are substituted in the alternate sequence.
   function automatic logic [2:0] select_for(input logic [2:0] st,
         input logic alt);
      logic [2:0] s;
      s = st;
      if (alt && st == `AMS_STATE_TEMP) begin
         s = ams_pkg::AMS_IN_DIE_TEMP;
      end else if (alt && st == `AMS_STATE_AUX) begin
         s = ams_pkg::AMS_IN_AUX_MON;
      end
      return s;
   endfunction : select_for

   // =======================================================================
   // Sequencer
   logic [2:0] state_q;
   logic [2:0] states_q;
   logic [1:0] tick_cnt_q;
   logic [1:0] conv_len_q;
   logic [1:0] conv_len_d;
   logic conv_end;
   logic last_state;
   logic begin_cycle;
   logic begin_conv;
   logic [2:0] next_state;
   logic next_alt;

   assign conv_len_d = result_width_22 ? `AMS_CONV_LONG :
      `AMS_CONV_SHORT;
   assign conv_end = (fsm_q == ams_pkg::AMS_SQ_RUN) & tick &
      (tick_cnt_q == conv_len_q - 2'h1);
   assign last_state = (state_q == states_q - 3'h1);
   assign begin_cycle = ((fsm_q == ams_pkg::AMS_SQ_IDLE) & tick) |
      (conv_end & last_state);
   assign begin_conv = ((fsm_q == ams_pkg::AMS_SQ_IDLE) & tick) |
      conv_end;
   assign alt_start = begin_cycle & alt_pending_q;
   assign next_state = begin_cycle ? `AMS_STATE_FIRST :
      state_q + 3'h1;
   assign next_alt = begin_cycle ? alt_pending_q : alt_cycle_active;

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         fsm_q <= ams_pkg::AMS_SQ_IDLE;
      end else begin
         case (fsm_q)
            ams_pkg::AMS_SQ_IDLE: begin
               if (tick) begin
                  fsm_q <= ams_pkg::AMS_SQ_RUN;
               end
            end
            ams_pkg::AMS_SQ_RUN: fsm_q <= ams_pkg::AMS_SQ_RUN;
            default: fsm_q <= ams_pkg::AMS_SQ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_q <= `AMS_STATE_FIRST;
         states_q <= `AMS_STATES_6;
         alt_cycle_active <= 1'b0;
         input_select <= ams_pkg::AMS_IN_PHASE_A_CUR;
      end else if (begin_conv) begin
         state_q <= next_state;
         alt_cycle_active <= next_alt;
         input_select <= select_for(next_state, next_alt);
         if (begin_cycle) begin
            // Latched per cycle so a mid-cycle write cannot cut it short.
            states_q <= states_for(
               cycle_and_chop_config_q[`AMS_DIV_MSB:`AMS_DIV_LSB]);
         end
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tick_cnt_q <= 2'h0;
         conv_len_q <= `AMS_CONV_SHORT;
      end else if (begin_conv) begin
         tick_cnt_q <= 2'h0;
         conv_len_q <= conv_len_d;
      end else if (tick && fsm_q == ams_pkg::AMS_SQ_RUN) begin
         tick_cnt_q <= tick_cnt_q + 2'h1;
      end
   end

   // =======================================================================
   // Start pulses
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         conv_start <= 1'b0;
         filter_start <= 1'b0;
         ce_pass_start <= 1'b0;
         cycle_end_event <= 1'b0;
      end else begin
         conv_start <= begin_conv;
         filter_start <= begin_conv;
         ce_pass_start <= begin_cycle;
         cycle_end_event <= conv_end & last_state;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         cycle_count_q <= 8'h00;
      end else if (conv_end && last_state) begin
         cycle_count_q <= cycle_count_q + 8'h01;
      end
   end

   // =======================================================================
   // Result write
   logic [21:0] result_meta_q;
   logic [21:0] result_sync_q;

   // The converter word changes on the slow edge, some clocks before the
   // tick that reads it, so both stages hold a settled word by then.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         result_meta_q <= 22'h00_0000;
         result_sync_q <= 22'h00_0000;
      end else begin
         result_meta_q <= filter_result;
         result_sync_q <= result_meta_q;
      end
   end

   // The word index is the selector code, so alternate samples land in
   // their own words and never overwrite a line sample.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         ram_we <= 1'b0;
         ram_addr <= 3'h0;
         ram_wdata <= 32'h0000_0000;
      end else begin
         ram_we <= conv_end;
         if (conv_end) begin
            ram_addr <= input_select;
            if (conv_len_q == `AMS_CONV_LONG) begin
               ram_wdata <= {10'h000, result_sync_q};
            end else begin
               ram_wdata <= {11'h000,
                  result_sync_q[`AMS_RES_BITS_SHORT-1:0]};
            end
         end
      end
   end

   // =======================================================================
   // Reference chopper
   ams_pkg::ams_chop_e chop_mode;

   assign chop_mode = ams_pkg::ams_chop_e'(
      cycle_and_chop_config_q[`AMS_CHOP_MSB:`AMS_CHOP_LSB]);

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         chop_polarity <= 1'b0;
      end else begin
         case (chop_mode)
            ams_pkg::AMS_CHOP_REGULAR: chop_polarity <= 1'b0;
            ams_pkg::AMS_CHOP_INVERTED: chop_polarity <= 1'b1;
            default: begin
               // Flipping only at the boundary keeps every sample of a
               // cycle on one polarity, so offsets cancel pairwise.
               if (conv_end && last_state) begin
                  chop_polarity <= ~chop_polarity;
               end
            end
         endcase
      end
   end

endmodule : ams_sequencer

// ### hw/ams_map.svh
`ifndef AMS_MAP_SVH
`define AMS_MAP_SVH

// ==========================================================================
// Register indices and byte addresses
`define AMS_IDX_EQU 16'h2000
`define AMS_IDX_CYC 16'h2002
`define AMS_IDX_ALT 16'h2005
`define AMS_IDX_STAT 16'h2008
`define AMS_ADDR_EQU (`AMS_IDX_EQU * 16'h0004)
`define AMS_ADDR_CYC (`AMS_IDX_CYC * 16'h0004)
`define AMS_ADDR_ALT (`AMS_IDX_ALT * 16'h0004)
`define AMS_ADDR_STAT (`AMS_IDX_STAT * 16'h0004)

// ==========================================================================
// Reset values
`define AMS_RST_EQU 8'h00
`define AMS_RST_CYC 8'h00
`define AMS_RST_ALT 8'h00

// ==========================================================================
// Field positions
`define AMS_EQU_MSB 7
`define AMS_EQU_LSB 5
`define AMS_DIV_MSB 7
`define AMS_DIV_LSB 6
`define AMS_CHOP_MSB 5
`define AMS_CHOP_LSB 4
`define AMS_ALT_BIT 2
`define AMS_FLEN_BIT 4

// ==========================================================================
// Counts
`define AMS_CONV_SHORT 2'h2
`define AMS_CONV_LONG 2'h3
`define AMS_STATES_2 3'h2
`define AMS_STATES_3 3'h3
`define AMS_STATES_4 3'h4
`define AMS_STATES_6 3'h6
`define AMS_STATE_FIRST 3'h0
`define AMS_STATE_TEMP 3'h0
`define AMS_STATE_AUX 3'h2
`define AMS_RES_BITS_SHORT 21
`define AMS_RES_BITS_LONG 22

`endif

// ### hw/ams_pkg.sv
package ams_pkg;

   // =======================================================================
   // Input selector codes, equal to the result word in compute data RAM.
   typedef enum logic [2:0] {
      AMS_IN_PHASE_A_CUR = 3'b000,
      AMS_IN_PHASE_A_VOLT = 3'b001,
      AMS_IN_PHASE_B_CUR = 3'b010,
      AMS_IN_PHASE_B_VOLT = 3'b011,
      AMS_IN_PHASE_C_CUR = 3'b100,
      AMS_IN_PHASE_C_VOLT = 3'b101,
      AMS_IN_DIE_TEMP = 3'b110,
      AMS_IN_AUX_MON = 3'b111
   } ams_input_e;

   // =======================================================================
   // Sequencer states.
   typedef enum logic [0:0] {
      AMS_SQ_IDLE = 1'b0,
      AMS_SQ_RUN = 1'b1
   } ams_fsm_e;

   // =======================================================================
   // Chopper modes.
   typedef enum logic [1:0] {
      AMS_CHOP_REGULAR = 2'b00,
      AMS_CHOP_INVERTED = 2'b01,
      AMS_CHOP_TOGGLE = 2'b10,
      AMS_CHOP_TOGGLE_ALT = 2'b11
   } ams_chop_e;

endpackage : ams_pkg

// ### hw/ams_edge_sync.sv
`timescale 1ns/1ps

// ==========================================================================
// Two-flop synchroniser with rising edge detect.
module ams_edge_sync (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic async_in,
   output logic rise_pulse
);

   logic meta_q;
   logic sync_q;
   logic last_q;

   // Only the second stage reads the first one.
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
         last_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
         last_q <= sync_q;
      end
   end

   assign rise_pulse = sync_q & ~last_q;

endmodule : ams_edge_sync

// ### sim/ams_afe_model.sv
`timescale 1ns/1ps

// ======================================================================
// Converter stand-in: a free-running base clock, scaled down so a run
// stays short, and a result word that carries the selected input code.
module ams_afe_model (
   input wire logic [2:0] input_select,
   output logic slow_base_clock,
   output logic [21:0] filter_result
);
   logic [15:0] count_q;
   initial begin
      slow_base_clock = 1'b0;
      count_q = 16'h0000;
      #1.3;
      forever #40 slow_base_clock = ~slow_base_clock;
   end
   always @(posedge slow_base_clock) count_q <= count_q + 16'h0001;
   // The top bits are set so that a dropped or kept 22nd bit shows.
   assign filter_result = {3'b111, count_q, input_select};
endmodule : ams_afe_model

// ### sim/ams_sequencer_sva.sv
`timescale 1ns/1ps

// ======================================================================
// Port-level checks on the sequencer.
module ams_sequencer_chk (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [2:0] input_select,
   input wire logic conv_start,
   input wire logic filter_start,
   input wire logic result_width_22,
   input wire logic chop_polarity,
   input wire logic ce_pass_start,
   input wire logic [2:0] meter_equation_select,
   input wire logic ram_we,
   input wire logic [2:0] ram_addr,
   input wire logic [31:0] ram_wdata,
   input wire logic cycle_end_event,
   input wire logic alt_cycle_active
);
   logic wr;
   assign wr = psel && penable && pwrite;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   chk_bad_addr: assert property (psel && penable && !(paddr inside
      {16'h8000, 16'h8008, 16'h8014, 16'h8020}) |-> pslverr && pready)
      else $error("unmapped access not refused");
   chk_pass_state: assert property (ce_pass_start |-> conv_start &&
      input_select inside {3'h0, 3'h6}) else $error("pass start misplaced");
   chk_filter_start: assert property (
      (conv_start || filter_start) |-> conv_start && filter_start)
      else $error("filter start apart");
   chk_we_word: assert property (ram_we |-> conv_start &&
      ram_addr == $past(input_select)) else $error("result word wrong");
   chk_conv_gap: assert property (conv_start |=> !conv_start [*8])
      else $error("conversion too short");
   chk_alt_slots: assert property (conv_start &&
      input_select[2:1] == 2'b11 |-> alt_cycle_active)
      else $error("substitute outside alt cycle");
   chk_alt_start: assert property (
      $rose(alt_cycle_active) |-> ce_pass_start)
      else $error("alt cycle off boundary");
   chk_cycle_end: assert property (
      cycle_end_event |-> ce_pass_start)
      else $error("cycle end without restart");
   chk_chop_hold: assert property ($changed(chop_polarity) |->
      cycle_end_event || $past(wr) || $past(wr, 2))
      else $error("chop moved inside cycle");
   chk_equ_follow: assert property (wr && paddr == 16'h8000 |=>
      meter_equation_select == $past(pwdata[7:5]))
      else $error("equation select not taken");
   chk_width_follow: assert property (wr && paddr == 16'h8014 |=>
      result_width_22 == $past(pwdata[4])) else $error("width not taken");
   chk_data_pad: assert property (
      ram_we |-> ram_wdata[31:22] == 10'h000)
      else $error("result not zero padded");
endmodule : ams_sequencer_chk

bind ams_sequencer ams_sequencer_chk u_chk (.clk_sys, .reset, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .input_select,
   .conv_start, .filter_start, .result_width_22, .chop_polarity,
   .ce_pass_start, .meter_equation_select, .ram_we, .ram_addr, .ram_wdata,
   .cycle_end_event, .alt_cycle_active);

// ### sim/testbench.sv
`timescale 1ns/1ps

// ======================================================================
// Self-checking bench for the sequencer.
module testbench;
   typedef struct {logic [7:0] cyc; int n;} ams_row_s;
   logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, ram_wdata;
   logic slow_base_clock, conv_start, filter_start, result_width_22;
   logic chop_polarity, ce_pass_start, ram_we, cycle_end_event;
   logic alt_cycle_active, p1, w21, alt1;
   logic [21:0] filter_result;
   logic [2:0] input_select, meter_equation_select, ram_addr;
   logic [2:0] seq [8];
   logic [2:0] alt_seq [6] = '{3'h6, 3'h1, 3'h7, 3'h3, 3'h4, 3'h5};
   logic [15:0] regs [3] = '{16'h8000, 16'h8008, 16'h8014};
   ams_row_s rows [4] = '{'{8'h00, 2}, '{8'h40, 3}, '{8'h80, 4},
      '{8'hc0, 6}};
   int fails, n_tests, n, gap;

   ams_sequencer dut (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .slow_base_clock, .filter_result,
      .input_select, .conv_start, .filter_start, .result_width_22,
      .chop_polarity, .ce_pass_start, .meter_equation_select, .ram_we,
      .ram_addr, .ram_wdata, .cycle_end_event, .alt_cycle_active);
   ams_afe_model model (.input_select, .slow_base_clock, .filter_result);

   always #2.5 clk_sys = ~clk_sys;

   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict

   task automatic apb(input logic w, input logic [15:0] a,
      input logic [7:0] d);
      int t;
      t = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         t++;
      end while (pready !== 1'b1 && t < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (t >= 50) begin
         fails++;
         print_verdict();
      end
   endtask : apb

   // Waits, bounded, for the next pass start seen at a falling edge.
   task automatic next_boundary;
      int t;
      t = 0;
      @(negedge clk_sys);
      while (ce_pass_start !== 1'b1 && t < 3000) begin
         @(negedge clk_sys);
         t++;
      end
      if (t >= 3000) begin
         fails++;
         print_verdict();
      end
   endtask : next_boundary

   // Records one whole selector cycle, from one pass start to the next.
   task automatic collect;
      int t, last;
      n = 0;
      t = 0;
      last = 0;
      next_boundary();
      do begin
         if (conv_start === 1'b1 && n < 8) begin
            seq[n] = input_select;
            if (n == 1) gap = t - last;
            if (n == 1) alt1 = alt_cycle_active;
            last = t;
            n++;
         end
         if (ram_we === 1'b1) w21 = ram_wdata[21];
         @(negedge clk_sys);
         t++;
      end while (ce_pass_start !== 1'b1 && t < 3000);
      if (t >= 3000) begin
         fails++;
         print_verdict();
      end
   endtask : collect

   always @(negedge clk_sys) begin
      if (ram_we === 1'b1) begin
         check("ram word", {29'h0, ram_addr}, {29'h0, ram_wdata[2:0]});
      end
   end

   initial begin
      clk_sys = 1'b0;
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0000_0000;
      fails = 0;
      n_tests = 0;
      repeat (8) @(posedge clk_sys);
      reset <= 1'b0;
      foreach (regs[i]) begin
         apb(1'b0, regs[i], 8'h00);
         check("reset value", 32'h0000_0000, rd);
         check("mapped err", 32'h0000_0000, {31'h0, err});
      end
      apb(1'b0, 16'h8004, 8'h00);
      check("unmapped err", 32'h0000_0001, {31'h0, err});
      apb(1'b1, 16'h8000, 8'ha0);
      apb(1'b0, 16'h8000, 8'h00);
      check("equation read", 32'h0000_00a0, rd);
      check("equation out", 5, meter_equation_select);
      foreach (rows[i]) begin
         apb(1'b1, 16'h8008, rows[i].cyc);
         collect();
         collect();
         check("states", rows[i].n, n);
         for (int k = 0; k < rows[i].n; k++) check("select", k, seq[k]);
         check("conv gap", 32, gap);
         check("width bit", 0, {31'h0, w21});
      end
      // One short request, set and cleared at once, as the host would.
      // Comparator interrupts live outside this block.
      apb(1'b1, 16'h8014, 8'h04);
      apb(1'b1, 16'h8014, 8'h00);
      collect();
      for (int k = 0; k < 6; k++) check("alt select", alt_seq[k], seq[k]);
      check("alt level", 1, {31'h0, alt1});
      collect();
      for (int k = 0; k < 6; k++) check("after alt", k, seq[k]);
      check("alt cleared", 0, {31'h0, alt1});
      apb(1'b1, 16'h8014, 8'h10);
      collect();
      collect();
      check("width out", 1, {31'h0, result_width_22});
      check("width bit", 1, {31'h0, w21});
      check("long gap", 48, gap);
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, 16'h8008, {2'b11, m[1:0], 4'h0});
         collect();
         collect();
         p1 = chop_polarity;
         // One boundary only, so a toggling mode shows a single flip.
         next_boundary();
         if (m < 2) check("chop fixed", m, {31'h0, chop_polarity});
         else check("chop toggle", {31'h0, ~p1}, {31'h0, chop_polarity});
      end
      // A second reset in mid-run must clear state and registers.
      @(posedge clk_sys);
      reset <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check("reset select", 0, input_select);
      check("reset ready", 1, {31'h0, pready});
      reset <= 1'b0;
      apb(1'b0, 16'h8008, 8'h00);
      check("cycle reg reset", 32'h0000_0000, rd);
      apb(1'b1, 16'h8020, 8'hff);
      check("status write err", 32'h0000_0001, {31'h0, err});
      print_verdict();
   end
endmodule : testbench
